/* File: verilog/flash_status_pkg.sv */
// Overview of operation
// RULE1: host reads the status byte twice before judging toggling.
// RULE2: on completion toggling stops; next read returns array data.
// RULE3: toggling with timeout high: host rechecks; still toggling means reset.
// RULE4: host restarts the toggle check after other work.
// RULE5: host avoids other-bank reads between toggle reads, else polls.
// RULE6: timeout flag goes 1 past the pulse-count limit.
// RULE7: 0 to 1 requests masked silently; other bits still program.
// RULE8: after timeout host resets; bank returns to read or suspend-read.
// RULE9: window indicator 0 in acceptance window, 1 after; commands restart it.
// RULE10: chip erase skips the acceptance timer and indicator.
// RULE11: open window takes sector erases; closed takes only suspend.
// RULE12: host checks the indicator around each further sector erase.
// RULE13: host always inside the window may skip the indicator.
// RULE14: abort flag 1 on buffer abort until abort reset; else 0.
// RULE15: polling and sector toggle valid only at a valid address.
// RULE16: program suspend: own sector reads invalid, others array.
// RULE17: suspend-read selected sector: poll 1, toggle still, timeout 0, sector toggles.
// RULE18: buffer programming polls inverted bit 7 of the last loaded word.
// RULE19: embedded program polls inverted bit 7 of the programmed data.
// RULE20: embedded erase polls 0, then 1 on completion or suspend.
// RULE21: main toggle inverts on each busy-bank read while running.
// RULE22: sector toggle inverts only in sectors selected for erase.
// RULE23: status bits on data bits 7, 6, 5, 3, 2 and 1.
package flash_status_pkg;

    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 16;
    localparam int SECTOR_W  = 4;
    localparam int BANK_W    = 4;
    localparam int PULSE_W   = 16;
    localparam int WINDOW_W  = 24;
    localparam int NUM_SECT_MAX = 1 << SECTOR_W;

    // ============
    // timing
    localparam int CLK_PERIOD_PS                = 5000;
    localparam int ERASE_ACCEPT_WINDOW_TIME_NS  = 50000;
    localparam int ERASE_ACCEPT_WINDOW_CYCLES   =
        (ERASE_ACCEPT_WINDOW_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MAX_PULSE_COUNT              = 1024;

    // ============
    // status byte layout
    localparam int POLL_POS        = 7;
    localparam int TOGGLE_POS      = 6;
    localparam int TIMEOUT_POS     = 5;
    localparam int WINDOW_POS      = 3;
    localparam int SECT_TOGGLE_POS = 2;
    localparam int ABORT_POS       = 1;

    localparam logic [DATA_W-1:0] INVALID_READ_WORD = 16'hFFFF;
    localparam logic [DATA_W-1:0] RESET_WORD        = 16'h0000;

    // ============
    // types
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_PROG,
        ST_PROG_SUSP,
        ST_BUF_PROG,
        ST_ERASE_WINDOW,
        ST_ERASE,
        ST_ERASE_SUSP,
        ST_ESP_PROG,
        ST_TIMEOUT,
        ST_BUF_ABORT
    } op_state_t;

    typedef struct packed {
        logic                prog;
        logic                buf_load;
        logic                buf_confirm;
        logic                sector_erase;
        logic                chip_erase;
        logic                erase_suspend;
        logic                erase_resume;
        logic                prog_suspend;
        logic                prog_resume;
        logic                reset;
        logic                buf_abort_reset;
        logic [BANK_W-1:0]   bank;
        logic [SECTOR_W-1:0] sector;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } cmd_t;

    typedef struct packed {
        logic                valid;
        logic [BANK_W-1:0]   bank;
        logic [SECTOR_W-1:0] sector;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   array_data;
    } read_req_t;

    typedef struct packed {
        logic pulse_tick;
        logic op_done;
        logic buf_abort;
    } algo_event_t;

    typedef struct packed {
        logic                  running;
        logic [WINDOW_W-1:0]   count;
    } window_state_t;

    typedef struct packed {
        op_state_t             state;
        logic                  from_esp;
        logic                  erasing;
        logic [BANK_W-1:0]     bank;
        logic [SECTOR_W-1:0]   prog_sector;
        logic [ADDR_W-1:0]     prog_addr;
        logic                  poll_src;
        logic [NUM_SECT_MAX-1:0] erase_sel;
        logic [PULSE_W-1:0]    pulses;
        logic                  main_toggle;
        logic                  sect_toggle;
        logic [DATA_W-1:0]     rd_data;
        logic                  rd_valid;
        logic [DATA_W-1:0]     prog_target;
        logic                  prog_start;
        logic                  erase_start;
    } status_state_t;

    function automatic logic [DATA_W-1:0] status_word(input logic poll,
                                                      input logic tog,
                                                      input logic tmo,
                                                      input logic win,
                                                      input logic stog,
                                                      input logic abrt);
        logic [DATA_W-1:0] w;
        w                  = '0;
        w[POLL_POS]        = poll;
        w[TOGGLE_POS]      = tog;
        w[TIMEOUT_POS]     = tmo;
        w[WINDOW_POS]      = win;
        w[SECT_TOGGLE_POS] = stog;
        w[ABORT_POS]       = abrt;
        return w;
    endfunction

endpackage

/* File: verilog/bit_program_mask.sv */
`timescale 1ns/1ps
module bit_program_mask
    import flash_status_pkg::*;
(
    input  wire logic [DATA_W-1:0] cur_word,
    input  wire logic [DATA_W-1:0] req_word,
    output logic      [DATA_W-1:0] target_word,
    output logic      [DATA_W-1:0] masked_bits
);
    // a cell can only go 1 to 0; upward requests drop out quietly
    assign target_word = cur_word & req_word;  // [RULE7]
    assign masked_bits = req_word & ~cur_word;
endmodule

/* File: verilog/erase_window_timer.sv */
`timescale 1ns/1ps
module erase_window_timer
    import flash_status_pkg::*;
#(
    parameter int WINDOW_CYCLES = ERASE_ACCEPT_WINDOW_CYCLES
)(
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic restart,
    input  wire logic cancel,
    output logic      window_open,
    output logic      expired
);
    initial begin
        if (WINDOW_CYCLES < 1 || WINDOW_CYCLES >= (1 << WINDOW_W))
            $error("erase_window_timer: WINDOW_CYCLES out of range");
    end

    window_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (cancel) begin
            s_d.running = 1'b0;
        end else if (restart) begin
            // each new sector erase command buys a full window again
            s_d.running = 1'b1;  // [RULE9]
            s_d.count   = WINDOW_W'(WINDOW_CYCLES - 1);
        end else if (s_q.running) begin
            if (s_q.count == '0) begin
                s_d.running = 1'b0;
            end else begin
                s_d.count = s_q.count - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign window_open = s_q.running;
    assign expired     = s_q.running && s_q.count == '0 && !restart && !cancel;
endmodule

/* File: verilog/flash_status_reporter.sv */
`timescale 1ns/1ps
module flash_status_reporter
    import flash_status_pkg::*;
#(
    parameter int NUM_SECTORS   = NUM_SECT_MAX,
    parameter int MAX_PULSES    = MAX_PULSE_COUNT,
    parameter int WINDOW_CYCLES = ERASE_ACCEPT_WINDOW_CYCLES
)(
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    input  wire cmd_t          cmd,
    input  wire algo_event_t   evt,
    input  wire read_req_t     rd,
    input  wire logic [DATA_W-1:0] cur_word,
    output logic [DATA_W-1:0]  rd_data,
    output logic               rd_valid,
    output logic [DATA_W-1:0]  prog_target,
    output logic               prog_start,
    output logic               erase_start,
    output logic [NUM_SECT_MAX-1:0] erase_sectors,
    output op_state_t          op_state,
    output logic               busy
);
    initial begin
        if (NUM_SECTORS < 1 || NUM_SECTORS > NUM_SECT_MAX)
            $error("flash_status_reporter: NUM_SECTORS out of range");
        if (MAX_PULSES < 1 || MAX_PULSES >= (1 << PULSE_W))
            $error("flash_status_reporter: MAX_PULSES out of range");
    end

    status_state_t s_q, s_d;

    // ============
    // helpers
    logic [DATA_W-1:0] masked_target;
    logic              win_open;
    logic              win_expired;
    logic              win_restart;
    logic              win_cancel;

    bit_program_mask u_mask (
        .cur_word    (cur_word),
        .req_word    (cmd.data),
        .target_word (masked_target),
        .masked_bits ()
    );

    erase_window_timer #(
        .WINDOW_CYCLES (WINDOW_CYCLES)
    ) u_window (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .restart     (win_restart),
        .cancel      (win_cancel),
        .window_open (win_open),
        .expired     (win_expired)
    );

    // the timer only serves sector erase, never chip erase
    assign win_restart = cmd.sector_erase &&
                         (s_q.state == ST_IDLE || s_q.state == ST_ERASE_WINDOW);  // [RULE10]
    assign win_cancel  = s_q.state != ST_ERASE_WINDOW && s_q.state != ST_IDLE;

    function automatic logic sector_ok(input logic [SECTOR_W-1:0] sec);
        return 32'(sec) < NUM_SECTORS;
    endfunction

    // ============
    // state update
    logic busy_bank_hit;
    logic sel_hit;

    always_comb begin
        s_d             = s_q;
        s_d.rd_valid    = 1'b0;
        s_d.prog_start  = 1'b0;
        s_d.erase_start = 1'b0;
        busy_bank_hit   = rd.bank == s_q.bank;
        sel_hit         = s_q.erase_sel[rd.sector];

        // ----- command and algorithm events
        unique case (s_q.state)
            ST_IDLE: begin
                if (cmd.prog || cmd.buf_load) begin
                    s_d.state       = cmd.prog ? ST_PROG : ST_BUF_PROG;
                    s_d.bank        = cmd.bank;
                    s_d.prog_addr   = cmd.addr;
                    s_d.prog_sector = cmd.sector;
                    // a masked bit never programs, so a word program polls what the cell will hold
                    s_d.poll_src    = cmd.prog ? masked_target[POLL_POS]  // [RULE19]
                                               : cmd.data[POLL_POS];  // [RULE18]
                    s_d.prog_target = cmd.prog ? masked_target : s_q.prog_target;  // [RULE7]
                    s_d.prog_start  = cmd.prog;
                    s_d.pulses      = '0;
                    s_d.from_esp    = 1'b0;
                    s_d.erasing     = 1'b0;
                end else if (cmd.sector_erase && sector_ok(cmd.sector)) begin
                    s_d.state     = ST_ERASE_WINDOW;
                    s_d.bank      = cmd.bank;
                    s_d.erase_sel = '0;
                    s_d.erase_sel[cmd.sector] = 1'b1;
                    s_d.pulses    = '0;
                    s_d.erasing   = 1'b1;
                end else if (cmd.chip_erase) begin
                    // straight into erase, no acceptance window
                    s_d.state       = ST_ERASE;  // [RULE10]
                    s_d.bank        = cmd.bank;
                    s_d.erase_sel   = NUM_SECT_MAX'((1 << NUM_SECTORS) - 1);
                    s_d.erase_start = 1'b1;
                    s_d.pulses      = '0;
                    s_d.erasing     = 1'b1;
                end
            end
            ST_BUF_PROG: begin
                if (evt.buf_abort) begin
                    s_d.state = ST_BUF_ABORT;  // [RULE14]
                end else if (cmd.buf_load) begin
                    // polling follows the last loaded location
                    s_d.prog_addr   = cmd.addr;  // [RULE18]
                    s_d.prog_sector = cmd.sector;
                    s_d.poll_src    = cmd.data[POLL_POS];  // [RULE18]
                end else if (cmd.buf_confirm) begin
                    s_d.prog_start = 1'b1;
                end
            end
            ST_ERASE_WINDOW: begin
                if (cmd.sector_erase && sector_ok(cmd.sector)) begin
                    s_d.erase_sel[cmd.sector] = 1'b1;  // [RULE11]
                end else if (win_expired) begin
                    s_d.state       = ST_ERASE;  // [RULE9]
                    s_d.erase_start = 1'b1;
                end
            end
            ST_ERASE: begin
                // every command but suspend is ignored while erasing
                if (cmd.erase_suspend) begin
                    s_d.state = ST_ERASE_SUSP;  // [RULE11]
                end
            end
            ST_ERASE_SUSP: begin
                if (cmd.erase_resume) begin
                    s_d.state = ST_ERASE;
                end else if (cmd.prog && !s_q.erase_sel[cmd.sector]) begin
                    s_d.state       = ST_ESP_PROG;
                    s_d.from_esp    = 1'b1;
                    s_d.prog_addr   = cmd.addr;
                    s_d.prog_sector = cmd.sector;
                    s_d.poll_src    = masked_target[POLL_POS];  // [RULE19]
                    s_d.prog_target = masked_target;  // [RULE7]
                    s_d.prog_start  = 1'b1;
                end
            end
            ST_PROG: begin
                if (cmd.prog_suspend) begin
                    s_d.state = ST_PROG_SUSP;
                end
            end
            ST_PROG_SUSP: begin
                if (cmd.prog_resume) begin
                    s_d.state = ST_PROG;
                end
            end
            ST_TIMEOUT: begin
                // reset lands in suspend-read when program ran under suspend
                if (cmd.reset) begin
                    s_d.state   = s_q.from_esp ? ST_ERASE_SUSP : ST_IDLE;  // [RULE8]
                    s_d.erasing = s_q.from_esp;
                end
            end
            ST_BUF_ABORT: begin
                // plain reset has no effect here
                if (cmd.buf_abort_reset) begin
                    s_d.state = ST_IDLE;  // [RULE14]
                end
            end
            ST_ESP_PROG: begin
            end
        endcase

        // ----- pulse budget and completion of running algorithms
        if (s_q.state == ST_PROG || s_q.state == ST_ESP_PROG || s_q.state == ST_ERASE ||
            (s_q.state == ST_BUF_PROG && !evt.buf_abort)) begin
            if (evt.op_done) begin
                s_d.state       = s_q.state == ST_ESP_PROG ? ST_ERASE_SUSP : ST_IDLE;  // [RULE2]
                s_d.main_toggle = 1'b0;
                s_d.sect_toggle = 1'b0;
                if (s_q.state != ST_ESP_PROG) begin
                    s_d.erase_sel = '0;
                end
            end else if (evt.pulse_tick) begin
                if (s_q.pulses == PULSE_W'(MAX_PULSES - 1)) begin
                    s_d.state = ST_TIMEOUT;  // [RULE6]
                end else begin
                    s_d.pulses = s_q.pulses + 1'b1;
                end
            end
        end

        // ----- read path
        if (rd.valid) begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data  = rd.array_data;
            if (busy_bank_hit) begin
                unique case (s_q.state)
                    ST_PROG, ST_ESP_PROG, ST_BUF_PROG, ST_BUF_ABORT: begin
                        // poll value is only meaningful at the program address
                        s_d.main_toggle = ~s_q.main_toggle;  // [RULE21]
                        s_d.rd_data     = status_word(~s_q.poll_src,  // [RULE15]
                                                      ~s_q.main_toggle, 1'b0, 1'b0, 1'b0,
                                                      s_q.state == ST_BUF_ABORT);  // [RULE14]
                    end
                    ST_TIMEOUT: begin
                        s_d.main_toggle = ~s_q.main_toggle;  // [RULE21]
                        s_d.rd_data     = status_word(s_q.erasing ? 1'b0 : ~s_q.poll_src,
                                                      ~s_q.main_toggle, 1'b1,  // [RULE6]
                                                      1'b0, 1'b0, 1'b0);  // [RULE14]
                    end
                    ST_ERASE_WINDOW, ST_ERASE: begin
                        s_d.main_toggle = ~s_q.main_toggle;  // [RULE21]
                        if (sel_hit) begin
                            s_d.sect_toggle = ~s_q.sect_toggle;  // [RULE22]
                        end
                        s_d.rd_data = status_word(1'b0, ~s_q.main_toggle, 1'b0,  // [RULE20]
                                                  s_q.state == ST_ERASE,  // [RULE9]
                                                  sel_hit ? ~s_q.sect_toggle : s_q.sect_toggle,
                                                  1'b0);  // [RULE23]
                    end
                    ST_ERASE_SUSP: begin
                        if (sel_hit) begin
                            s_d.sect_toggle = ~s_q.sect_toggle;  // [RULE22]
                            s_d.rd_data     = status_word(1'b1, s_q.main_toggle, 1'b0, 1'b0,
                                                          ~s_q.sect_toggle, 1'b0);  // [RULE17]
                        end
                    end
                    ST_PROG_SUSP: begin
                        if (rd.sector == s_q.prog_sector) begin
                            s_d.rd_data = INVALID_READ_WORD;  // [RULE16]
                        end
                    end
                    ST_IDLE: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q       <= '0;
            s_q.state <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ============
    // outputs
    assign rd_data       = s_q.rd_data;
    assign rd_valid      = s_q.rd_valid;
    assign prog_target   = s_q.prog_target;
    assign prog_start    = s_q.prog_start;
    assign erase_start   = s_q.erase_start;
    assign erase_sectors = s_q.erase_sel;
    assign op_state      = s_q.state;
    assign busy          = s_q.state != ST_IDLE;
endmodule

/* File: verif/flash_status_reporter_asserts.sv */
`timescale 1ns/1ps
module flash_status_reporter_asserts
    import flash_status_pkg::*;
#(
    parameter int MAX_PULSES    = MAX_PULSE_COUNT,
    parameter int WINDOW_CYCLES = ERASE_ACCEPT_WINDOW_CYCLES
)(
    input wire logic                    ref_clk,
    input wire logic                    rst_b,
    input wire cmd_t                    cmd,
    input wire algo_event_t             evt,
    input wire read_req_t               rd,
    input wire logic [DATA_W-1:0]       cur_word,
    input wire logic [DATA_W-1:0]       rd_data,
    input wire logic                    rd_valid,
    input wire logic [DATA_W-1:0]       prog_target,
    input wire logic                    prog_start,
    input wire logic                    erase_start,
    input wire logic [NUM_SECT_MAX-1:0] erase_sectors,
    input wire op_state_t               op_state,
    input wire logic                    busy
);
    // ============
    // busy bank tracking
    logic [BANK_W-1:0] bank_q;
    logic [ADDR_W-1:0] addr_q;
    logic [15:0]       ticks_q;
    logic [23:0]       win_q;
    logic              own_rd;
    // polling is valid only at the operation's own address
    assign own_rd = rd.valid && rd.bank == bank_q && rd.addr == addr_q && !evt.op_done;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_q  <= '0;
            addr_q  <= '0;
            ticks_q <= '0;
            win_q   <= '0;
        end else begin
            if (!busy && (cmd.prog || cmd.sector_erase || cmd.chip_erase || cmd.buf_load)) begin
                bank_q <= cmd.bank;
                addr_q <= cmd.addr;
            end
            ticks_q <= (op_state == ST_PROG) ? ticks_q + 16'(evt.pulse_tick) : 16'h0000;
            win_q   <= (cmd.sector_erase && op_state inside {ST_IDLE, ST_ERASE_WINDOW}) ?
                       24'h000000 : win_q + 24'h000001;
        end
    end
    // ============
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence own_read(op_state_t st);
        own_rd && op_state == st;
    endsequence
    chk_idle_array: assert property (rd.valid && op_state == ST_IDLE && !cmd.prog
        |=> rd_valid && rd_data == $past(rd.array_data)) else $error("idle read not array");
    chk_prog_mask: assert property (cmd.prog && op_state == ST_IDLE
        |=> prog_start && prog_target == ($past(cur_word) & $past(cmd.data)))
        else $error("program mask wrong");
    chk_prog_poll: assert property (own_read(ST_PROG)
        |=> rd_data[7] == ~prog_target[7] && rd_data[5:1] == 5'h00) else $error("poll wrong");
    chk_toggle_flip: assert property (own_read(ST_PROG) ##2 own_read(ST_PROG)
        |=> rd_data[6] != $past(rd_data[6], 2)) else $error("toggle stuck");
    chk_pulse_limit: assert property (op_state == ST_PROG && !evt.op_done && !cmd.prog_suspend
        |=> (op_state == ST_TIMEOUT) == ($past(ticks_q) == MAX_PULSES - 1
        && $past(evt.pulse_tick))) else $error("pulse limit wrong");
    chk_timeout_flag: assert property (own_read(ST_TIMEOUT)
        |=> rd_data[5] && !rd_data[1]) else $error("timeout flag low");
    chk_window_bit: assert property (own_read(ST_ERASE_WINDOW)
        |=> !rd_data[3] && !rd_data[7]) else $error("window bit wrong");
    chk_window_len: assert property (erase_start && $past(op_state) == ST_ERASE_WINDOW
        |-> win_q inside {[WINDOW_CYCLES-3:WINDOW_CYCLES+2]}) else $error("window length");
    chk_erase_bits: assert property (own_read(ST_ERASE) ##0 erase_sectors[rd.sector]
        |=> rd_data[3] && !rd_data[7]) else $error("erase status wrong");
    chk_chip_start: assert property (cmd.chip_erase && op_state == ST_IDLE
        |=> erase_start && op_state == ST_ERASE) else $error("chip erase late");
    chk_suspend_read: assert property (own_read(ST_ERASE_SUSP)
        ##0 erase_sectors[rd.sector] |=> rd_data[7] && !rd_data[5]) else $error("suspend status");
    chk_abort_flag: assert property (own_read(ST_BUF_ABORT)
        |=> rd_data[1] && !rd_data[5]) else $error("abort flag low");
endmodule

bind flash_status_reporter flash_status_reporter_asserts #(
    .MAX_PULSES(MAX_PULSES), .WINDOW_CYCLES(WINDOW_CYCLES)
) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .cmd(cmd), .evt(evt), .rd(rd), .cur_word(cur_word),
    .rd_data(rd_data), .rd_valid(rd_valid), .prog_target(prog_target),
    .prog_start(prog_start), .erase_start(erase_start), .erase_sectors(erase_sectors),
    .op_state(op_state), .busy(busy)
);

/* File: verif/flash_host_model.sv */
`timescale 1ns/1ps
module flash_host_model
    import flash_status_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic [DATA_W-1:0] rd_data,
    output cmd_t                   cmd,
    output read_req_t              rd
);
    initial begin
        cmd = '0;
        rd  = '0;
    end
    // ============
    // released fields show inverted stale values
    task automatic issue(input cmd_t c);
        @(posedge ref_clk);
        cmd <= c;
        @(posedge ref_clk);
        cmd <= {11'h000, ~c[$bits(cmd_t)-12:0]};
    endtask
    task automatic read(input read_req_t r, output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        rd <= r;
        @(posedge ref_clk);
        rd <= {1'b0, ~r[$bits(read_req_t)-2:0]};
        #1 d = rd_data;
    endtask
endmodule

/* File: verif/flash_status_reporter_test.sv */
`timescale 1ns/1ps
module flash_status_reporter_test
    import flash_status_pkg::*;
;
    localparam int MAXP = 8;
    localparam int WIN  = 20;
    logic              ref_clk;
    logic              rst_b;
    algo_event_t       evt;
    cmd_t              cmd;
    read_req_t         rd;
    logic [DATA_W-1:0] cur_word, rd_data, prog_target, d1, d2, arr;
    logic              rd_valid, prog_start, erase_start, busy;
    logic [15:0]       erase_sectors;
    op_state_t         op_state;
    logic [3:0]        bk, sc;
    logic [15:0]       ad, dt;
    int                n_errors = 0;
    int                comparisons = 0;
    int                n;

    flash_status_reporter #(.MAX_PULSES(MAXP), .WINDOW_CYCLES(WIN)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .cmd(cmd), .evt(evt), .rd(rd),
        .cur_word(cur_word), .rd_data(rd_data), .rd_valid(rd_valid),
        .prog_target(prog_target), .prog_start(prog_start), .erase_start(erase_start),
        .erase_sectors(erase_sectors), .op_state(op_state), .busy(busy));
    flash_host_model host (.ref_clk(ref_clk), .rd_data(rd_data), .cmd(cmd), .rd(rd));

    // ============
    // helpers
    task automatic conclude();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // k indexes the cmd_t flags, 0 is prog
    task automatic go(input int k);
        cmd_t c;
        c = {11'h000, bk, sc, ad, dt};
        c[$bits(cmd_t)-1-k] = 1'b1;
        host.issue(c);
        #1;
    endtask
    task automatic rdq(input logic [3:0] b, input logic [3:0] s, output logic [15:0] d);
        host.read({1'b1, b, s, ad, arr}, d);
    endtask
    task automatic ev(input algo_event_t e);
        @(posedge ref_clk);
        evt <= e;
        @(posedge ref_clk);
        evt <= '0;
    endtask
    task automatic pair(input logic [3:0] s);
        rdq(bk, s, d1);
        rdq(bk, s, d2);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        n_errors++;
        conclude();
    end

    // ============
    // main sequence
    initial begin
        {rst_b, evt, cur_word, arr, bk, sc, ad, dt} = '0;
        void'($urandom(32'hA1660702));
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1 check({busy, rd_valid}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            {bk, sc, ad, dt, arr} = {$urandom, $urandom, $urandom};
            cur_word <= 16'($urandom);
            go(0);
            check(prog_target, cur_word & dt);
            pair(sc);
            check({d1[7], d1[5:1]}, {~prog_target[7], 5'h00});
            check(16'(d1[6] ^ d2[6]), 16'h0001);
            if (i == 0) begin
                repeat (MAXP) ev(3'h4);
                pair(sc);
                check(16'(d2[5] & (d1[6] ^ d2[6])), 16'h0001);
                go(9);
            end else begin
                ev(3'h2);
                pair(sc);
                check(d1 | d2, arr);
            end
            check(16'(op_state), 16'(ST_IDLE));
        end
        go(0);
        go(7);
        rdq(bk, sc, d1);
        check(d1, INVALID_READ_WORD);
        rdq(bk, sc + 4'h1, d1);
        check(d1, arr);
        go(8);
        ev(3'h2);
        sc = 4'h2;
        go(3);
        rdq(bk, sc, d1);
        check(d1 & 16'h0088, 16'h0000);
        sc = 4'h9;
        go(3);
        for (n = 0; !erase_start && n < 4 * WIN; n++) @(posedge ref_clk) #1;
        check(16'(n >= WIN - 2 && n <= WIN + 2), 16'h0001);
        sc = 4'h5;
        go(3);
        go(9);
        check(erase_sectors, 16'h0204);
        check(16'(op_state), 16'(ST_ERASE));
        pair(4'h2);
        check(d1[7:2], {1'b0, ~d2[6], 3'b001, ~d2[2]});
        pair(4'h5);
        check(16'(d1[2] ^ d2[2]), 16'h0000);
        go(5);
        pair(4'h2);
        check({d1[7], d1[5], d1[6] ^ d2[6], d1[2] ^ d2[2]}, 4'h9);
        rdq(bk, 4'h5, d1);
        check(d1, arr);
        go(6);
        ev(3'h2);
        go(4);
        check(16'(erase_start), 16'h0001);
        check(erase_sectors, 16'hFFFF);
        rdq(bk, sc, d1);
        check(16'(d1[3]), 16'h0001);
        ev(3'h2);
        cur_word <= 16'hFFFF;
        repeat (3) begin
            {ad, dt} = $urandom;
            go(1);
        end
        go(2);
        rdq(bk, sc, d1);
        check({d1[7], d1[5:1]}, {~dt[7], 5'h00});
        ev(3'h1);
        rdq(bk, sc, d1);
        check(16'(d1[1]), 16'h0001);
        go(9);
        check(16'(op_state), 16'(ST_BUF_ABORT));
        go(10);
        check(16'(op_state), 16'(ST_IDLE));
        conclude();
    end
endmodule
